/* File: pif_pkg.sv */
// Package with register map, field layout and carriers for request flags 6-8
// -----------------------------------------------------------------------
// Notes on behaviour
// - Flags set by source regardless of enables
// - Flag reads one after event, zero otherwise
// - Writable flags stay set until software clears
// - Register six: eight writable flags, reset zero
// - Register seven: mixed writable and summary bits
// - PWM parameter flag follows group register OR
// - I2C error flag follows error register OR
// - I2C general flag follows protocol register OR
// - I2C buffer flags follow I2C buffer state
// - Register eight: four writable, four summary bits
// - UART general flag follows UART irq OR
// - UART framing flag follows error register OR
// - UART buffer flags ignore software writes
// -----------------------------------------------------------------------
package pif_pkg;
    // -------------------------------------------------------------------
    // Register map
    // -------------------------------------------------------------------
    localparam logic [11:0] PIF_OFS_REQ6 = 12'h4B4; // Request register six
    localparam logic [11:0] PIF_OFS_REQ7 = 12'h4B5; // Request register seven
    localparam logic [11:0] PIF_OFS_REQ8 = 12'h4B6; // Request register eight
    localparam logic [11:0] PIF_OFS_STAT = 12'h4C0; // Sticky event status
    localparam logic [11:0] PIF_OFS_MASK = 12'h4C1; // Interrupt mask
    localparam logic [7:0]  PIF_RST_REQ  = 8'h00;   // Reset of all flags
    localparam logic [7:0]  PIF_RST_MASK = 8'h00;   // Mask reset: all off
    localparam logic [7:0]  PIF_RST_STAT = 8'h00;   // Status reset: none seen
    // Bits that software may write in each request register
    localparam logic [7:0]  PIF_WMASK6   = 8'hFF;
    localparam logic [7:0]  PIF_WMASK7   = 8'h60;
    localparam logic [7:0]  PIF_WMASK8   = 8'hF0;
    // Bits that exist at all in register seven (bit 4 is absent)
    localparam logic [7:0]  PIF_IMPL7    = 8'hEF;
    // Summary bit positions
    localparam int PIF_B7_PWM  = 7;
    localparam int PIF_B7_I2CE = 3;
    localparam int PIF_B7_I2CG = 2;
    localparam int PIF_B7_I2CT = 1;
    localparam int PIF_B7_I2CR = 0;
    localparam int PIF_B8_UG   = 3;
    localparam int PIF_B8_UE   = 2;
    localparam int PIF_B8_UT   = 1;
    localparam int PIF_B8_UR   = 0;

    // Register bus request carrier
    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } pif_bus_t;

    // Source registers inside peripherals feeding summary flags
    typedef struct packed {
        logic [7:0] pwm_three_group_irq_reg;
        logic [7:0] i2c_one_error_reg;
        logic [7:0] i2c_one_protocol_irq_reg;
        logic       i2c_one_transmit_flag;
        logic       i2c_one_receive_flag;
        logic [7:0] uart_two_irq_reg;
        logic [7:0] uart_two_error_reg;
        logic       uart_two_transmit_flag;
        logic       uart_two_receive_flag;
    } pif_src_t;
endpackage

/* File: pif_flag_reg.sv */
// Module holding one byte of hardware-set, software-cleared flags
`timescale 1ns/1ps
`default_nettype none
module pif_flag_reg #(
    parameter logic [7:0] WMASK = 8'hFF // Writable, hardware-set bits
) (
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    // Event and software write
    input  wire logic [7:0] set_pulse,
    input  wire logic       wr_en,
    input  wire logic [7:0] wr_data,
    // Flag state
    output logic [7:0]      flags_r
);
    logic [7:0] flags_nxt; // Next flag value

    // Writes replace bits; a same-cycle event still wins over a clear
    always_comb begin
        flags_nxt = flags_r;
        if (wr_en) begin
            flags_nxt = wr_data & WMASK;
        end
        flags_nxt = (flags_nxt | set_pulse) & WMASK;
    end

    // Flags hold until software writes them back to zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            flags_r <= pif_pkg::PIF_RST_REQ;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // A set flag never drops without a write
    property p_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        (!wr_en) |=> ((flags_r & $past(flags_r)) == $past(flags_r));
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
endmodule
`default_nettype wire

/* File: pif_top.sv */
// Top module for peripheral request registers six to eight
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pif_top (
    // Clock and reset
    input  wire logic              sys_clk,
    input  wire logic              sys_rst,
    // Register bus
    input  wire pif_pkg::pif_bus_t bus_in,
    output logic [7:0]             rdata_r,
    // Event pulses for writable flags
    input  wire logic [7:0]        set6_pulse,
    input  wire logic [7:0]        set7_pulse,
    input  wire logic [7:0]        set8_pulse,
    // Peripheral source registers
    input  wire pif_pkg::pif_src_t src_in,
    // Interrupt
    output logic                   irq
);
    // -------------------------------------------------------------------
    // Writable flag bytes
    // -------------------------------------------------------------------
    logic [7:0] req6_r;        // Register six state
    logic [7:0] req7w_r;       // Writable part of register seven
    logic [7:0] req8w_r;       // Writable part of register eight
    logic [7:0] req7;          // Full view of register seven
    logic [7:0] req8;          // Full view of register eight
    logic [7:0] stat_r;        // Sticky event status
    logic [7:0] stat_nxt;      // Next status
    logic [7:0] mask_r;        // Interrupt mask
    logic [7:0] sum_prev_r;    // Summary bits last cycle, for edges
    logic [7:0] sum_now;       // Summary bits this cycle
    logic [7:0] sum_rise;      // Summary bits that rose this cycle
    logic       wr6_hit;       // Write aimed at register six
    logic       wr7_hit;       // Write aimed at register seven
    logic       wr8_hit;       // Write aimed at register eight
    logic       wrm_hit;       // Write aimed at the mask
    logic       rds_hit;       // Read aimed at the status

    // Decode a write strobe for one address
    function automatic logic wr_hit(input pif_pkg::pif_bus_t b,
                                    input logic [11:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // Decode a read strobe for one address
    function automatic logic rd_hit(input pif_pkg::pif_bus_t b,
                                    input logic [11:0] a);
        return b.rd && (b.addr == a);
    endfunction

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    // One comparator per target, shared by the logic and the checks
    assign wr6_hit = wr_hit(bus_in, pif_pkg::PIF_OFS_REQ6);
    assign wr7_hit = wr_hit(bus_in, pif_pkg::PIF_OFS_REQ7);
    assign wr8_hit = wr_hit(bus_in, pif_pkg::PIF_OFS_REQ8);
    assign wrm_hit = wr_hit(bus_in, pif_pkg::PIF_OFS_MASK);
    assign rds_hit = rd_hit(bus_in, pif_pkg::PIF_OFS_STAT);

    pif_flag_reg #(.WMASK(pif_pkg::PIF_WMASK6)) u_req6 (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_pulse (set6_pulse),
        .wr_en     (wr6_hit),
        .wr_data   (bus_in.wdata),
        .flags_r   (req6_r)
    );
    pif_flag_reg #(.WMASK(pif_pkg::PIF_WMASK7)) u_req7 (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_pulse (set7_pulse),
        .wr_en     (wr7_hit),
        .wr_data   (bus_in.wdata),
        .flags_r   (req7w_r)
    );
    pif_flag_reg #(.WMASK(pif_pkg::PIF_WMASK8)) u_req8 (
        .sys_clk   (sys_clk),
        .sys_rst   (sys_rst),
        .set_pulse (set8_pulse),
        .wr_en     (wr8_hit),
        .wr_data   (bus_in.wdata),
        .flags_r   (req8w_r)
    );

    // -------------------------------------------------------------------
    // Summary flags, live OR of peripheral sources
    // -------------------------------------------------------------------
    // Combinational so they clear the same cycle the source empties;
    // writes never reach them since they hold no state here.
    always_comb begin
        req7 = req7w_r;
        req7[pif_pkg::PIF_B7_PWM]  = |src_in.pwm_three_group_irq_reg;
        req7[pif_pkg::PIF_B7_I2CE] = |src_in.i2c_one_error_reg;
        req7[pif_pkg::PIF_B7_I2CG] = |src_in.i2c_one_protocol_irq_reg;
        req7[pif_pkg::PIF_B7_I2CT] = src_in.i2c_one_transmit_flag;
        req7[pif_pkg::PIF_B7_I2CR] = src_in.i2c_one_receive_flag;
        req7 = req7 & pif_pkg::PIF_IMPL7;
        req8 = req8w_r;
        req8[pif_pkg::PIF_B8_UG] = |src_in.uart_two_irq_reg;
        req8[pif_pkg::PIF_B8_UE] = |src_in.uart_two_error_reg;
        req8[pif_pkg::PIF_B8_UT] = src_in.uart_two_transmit_flag;
        req8[pif_pkg::PIF_B8_UR] = src_in.uart_two_receive_flag;
    end

    // Status bit per register: 0 six, 1 seven, 2 eight
    assign sum_now = {5'h00, |req8, |req7, |req6_r};

    // Only a rise counts, so a flag that stays set raises status once
    assign sum_rise = sum_now & ~sum_prev_r;

    // -------------------------------------------------------------------
    // Sticky status and mask
    // -------------------------------------------------------------------
    // Rising of any register's OR sets status; a read clears, set wins
    always_comb begin
        stat_nxt = stat_r;
        if (rds_hit) begin
            stat_nxt = 8'h00;
        end
        stat_nxt = stat_nxt | sum_rise;
    end

    // Status and edge history
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stat_r     <= pif_pkg::PIF_RST_STAT;
            sum_prev_r <= pif_pkg::PIF_RST_STAT;
        end else begin
            stat_r     <= stat_nxt;
            sum_prev_r <= sum_now;
        end
    end

    // Mask register
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            mask_r <= pif_pkg::PIF_RST_MASK;
        end else if (wrm_hit) begin
            mask_r <= bus_in.wdata & 8'h07;
        end
    end

    // Level interrupt while an unmasked status bit stands
    assign irq = |(stat_r & mask_r);

    // -------------------------------------------------------------------
    // Read data, one cycle after the strobe
    // -------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_r <= 8'h00;
        end else if (bus_in.rd) begin
            case (bus_in.addr)
                pif_pkg::PIF_OFS_REQ6: rdata_r <= req6_r;
                pif_pkg::PIF_OFS_REQ7: rdata_r <= req7;
                pif_pkg::PIF_OFS_REQ8: rdata_r <= req8;
                pif_pkg::PIF_OFS_STAT: rdata_r <= stat_r;
                pif_pkg::PIF_OFS_MASK: rdata_r <= mask_r;
                default:               rdata_r <= 8'h00;   // Unmapped
            endcase
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    sequence s_rd6;
        bus_in.rd && bus_in.addr == pif_pkg::PIF_OFS_REQ6;
    endsequence
    property p_rd6;
        @(posedge sys_clk) disable iff (sys_rst)
        s_rd6 |=> (rdata_r == $past(req6_r));
    endproperty
    a_rd6: assert property (p_rd6) else $error("read six wrong");

    property p_set6;
        @(posedge sys_clk) disable iff (sys_rst)
        set6_pulse[0] |=> req6_r[0];
    endproperty
    a_set6: assert property (p_set6) else $error("event lost");

    property p_set8;
        @(posedge sys_clk) disable iff (sys_rst)
        set8_pulse[7] |=> req8[7];
    endproperty
    a_set8: assert property (p_set8) else $error("scan event lost");

    property p_pwm;
        @(posedge sys_clk) disable iff (sys_rst)
        req7[7] == (src_in.pwm_three_group_irq_reg != 8'h00);
    endproperty
    a_pwm: assert property (p_pwm) else $error("pwm summary");

    property p_i2ce;
        @(posedge sys_clk) disable iff (sys_rst)
        req7[3] == (src_in.i2c_one_error_reg != 8'h00);
    endproperty
    a_i2ce: assert property (p_i2ce) else $error("i2c err summary");

    property p_i2cg;
        @(posedge sys_clk) disable iff (sys_rst)
        req7[2] == (src_in.i2c_one_protocol_irq_reg != 8'h00);
    endproperty
    a_i2cg: assert property (p_i2cg) else $error("i2c summary");

    property p_ug;
        @(posedge sys_clk) disable iff (sys_rst)
        req8[3] == (src_in.uart_two_irq_reg != 8'h00);
    endproperty
    a_ug: assert property (p_ug) else $error("uart summary");

    property p_ue;
        @(posedge sys_clk) disable iff (sys_rst)
        req8[2] == (src_in.uart_two_error_reg != 8'h00);
    endproperty
    a_ue: assert property (p_ue) else $error("uart err summary");

    property p_gap;
        @(posedge sys_clk) disable iff (sys_rst)
        req7[4] == 1'b0;
    endproperty
    a_gap: assert property (p_gap) else $error("bit four set");

    property p_irq;
        @(posedge sys_clk) disable iff (sys_rst)
        // A mask write in the same cycle may hide the rise; leave it out
        (sum_rise[0] && mask_r[0] && !wrm_hit) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    // -------------------------------------------------------------------
    // Checks on events and writes
    // -------------------------------------------------------------------
    // Every event bit of register six lands, not only bit zero
    property p_set6w;
        @(posedge sys_clk) disable iff (sys_rst)
        (set6_pulse != 8'h00) |=>
            ((req6_r & $past(set6_pulse)) == $past(set6_pulse));
    endproperty
    a_set6w: assert property (p_set6w) else $error("six lost");

    // Events on register seven only act on its writable bits
    property p_set7;
        @(posedge sys_clk) disable iff (sys_rst)
        ((set7_pulse & pif_pkg::PIF_WMASK7) != 8'h00) |=>
            (((req7 & $past(set7_pulse)) & pif_pkg::PIF_WMASK7) ==
             ($past(set7_pulse) & pif_pkg::PIF_WMASK7));
    endproperty
    a_set7: assert property (p_set7) else $error("seven lost");

    // Events on register eight only act on its upper nibble
    property p_set8w;
        @(posedge sys_clk) disable iff (sys_rst)
        ((set8_pulse & pif_pkg::PIF_WMASK8) != 8'h00) |=>
            (((req8 & $past(set8_pulse)) & pif_pkg::PIF_WMASK8) ==
             ($past(set8_pulse) & pif_pkg::PIF_WMASK8));
    endproperty
    a_set8w: assert property (p_set8w) else $error("eight lost");

    // A write with no event beside it stores the written bits
    sequence s_wr6;
        wr6_hit && (set6_pulse == 8'h00);
    endsequence
    property p_wr6;
        @(posedge sys_clk) disable iff (sys_rst)
        s_wr6 |=> (req6_r == $past(bus_in.wdata));
    endproperty
    a_wr6: assert property (p_wr6) else $error("write six");

    sequence s_wr7;
        wr7_hit && ((set7_pulse & pif_pkg::PIF_WMASK7) == 8'h00);
    endsequence
    property p_wr7;
        @(posedge sys_clk) disable iff (sys_rst)
        s_wr7 |=> ((req7 & pif_pkg::PIF_WMASK7) ==
                   ($past(bus_in.wdata) & pif_pkg::PIF_WMASK7));
    endproperty
    a_wr7: assert property (p_wr7) else $error("write seven");

    sequence s_wr8;
        wr8_hit && ((set8_pulse & pif_pkg::PIF_WMASK8) == 8'h00);
    endsequence
    property p_wr8;
        @(posedge sys_clk) disable iff (sys_rst)
        s_wr8 |=> ((req8 & pif_pkg::PIF_WMASK8) ==
                   ($past(bus_in.wdata) & pif_pkg::PIF_WMASK8));
    endproperty
    a_wr8: assert property (p_wr8) else $error("write eight");

    // -------------------------------------------------------------------
    // Checks on buffer flags
    // -------------------------------------------------------------------
    // Buffer flags mirror the peripheral; no write can move them
    property p_i2cb;
        @(posedge sys_clk) disable iff (sys_rst)
        (req7[1] == src_in.i2c_one_transmit_flag) &&
        (req7[0] == src_in.i2c_one_receive_flag);
    endproperty
    a_i2cb: assert property (p_i2cb) else $error("i2c buffers");

    property p_ub;
        @(posedge sys_clk) disable iff (sys_rst)
        (req8[1] == src_in.uart_two_transmit_flag) &&
        (req8[0] == src_in.uart_two_receive_flag);
    endproperty
    a_ub: assert property (p_ub) else $error("uart buffers");

    // -------------------------------------------------------------------
    // Checks on read path, status and mask
    // -------------------------------------------------------------------
    sequence s_rd7;
        rd_hit(bus_in, pif_pkg::PIF_OFS_REQ7);
    endsequence
    property p_rd7;
        @(posedge sys_clk) disable iff (sys_rst)
        s_rd7 |=> (rdata_r == $past(req7));
    endproperty
    a_rd7: assert property (p_rd7) else $error("read seven");

    sequence s_rd8;
        rd_hit(bus_in, pif_pkg::PIF_OFS_REQ8);
    endsequence
    property p_rd8;
        @(posedge sys_clk) disable iff (sys_rst)
        s_rd8 |=> (rdata_r == $past(req8));
    endproperty
    a_rd8: assert property (p_rd8) else $error("read eight");

    // A read clears the status unless a new rise lands the same cycle
    sequence s_rds;
        rds_hit && (sum_rise == 8'h00);
    endsequence
    property p_stat_clr;
        @(posedge sys_clk) disable iff (sys_rst)
        s_rds |=> (stat_r == 8'h00);
    endproperty
    a_stat_clr: assert property (p_stat_clr) else $error("status kept");

    property p_stat_set;
        @(posedge sys_clk) disable iff (sys_rst)
        (sum_rise != 8'h00) |=>
            ((stat_r & $past(sum_rise)) == $past(sum_rise));
    endproperty
    a_stat_set: assert property (p_stat_set) else $error("rise lost");

    property p_mask;
        @(posedge sys_clk) disable iff (sys_rst)
        wrm_hit |=> (mask_r == ($past(bus_in.wdata) & 8'h07));
    endproperty
    a_mask: assert property (p_mask) else $error("mask write");
endmodule
`default_nettype wire

/* File: pif_periph_model.sv */
// Peripheral-side model: event pulses and source register contents
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
    // Clock
    input  wire logic        sys_clk,
    // Event pulses and peripheral state
    output logic [7:0]       set6_pulse,
    output logic [7:0]       set7_pulse,
    output logic [7:0]       set8_pulse,
    output var pif_pkg::pif_src_t src_out
);
    // ---------------------------------------------------------------
    // Peripheral actions
    // ---------------------------------------------------------------
    // Quiet peripherals at time zero
    initial begin
        set6_pulse = 8'h00;
        set7_pulse = 8'h00;
        set8_pulse = 8'h00;
        src_out    = '0;
    end
    // One-cycle events; enables play no part in raising them
    task automatic pulse(input logic [7:0] a6, a7, a8);
        @(posedge sys_clk);
        set6_pulse <= a6;
        set7_pulse <= a7;
        set8_pulse <= a8;
        @(posedge sys_clk);
        set6_pulse <= 8'h00;
        set7_pulse <= 8'h00;
        set8_pulse <= 8'h00;
    endtask
    // Source registers follow the peripheral's own state
    task automatic load_src(input pif_pkg::pif_src_t s);
        @(posedge sys_clk);
        src_out <= s;
    endtask
    // Clear-buffers command empties both I2C buffer conditions
    task automatic clear_buffers();
        @(posedge sys_clk);
        src_out.i2c_one_transmit_flag <= 1'b0;
        src_out.i2c_one_receive_flag  <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: peripheral_interrupt_flags_6_to_8_tb_top.sv */
// Self-checking bench for request registers six to eight
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: got %0h exp %0h", $time, a, b); end end
module peripheral_interrupt_flags_6_to_8_tb_top;
    // ---------------------------------------------------------------
    // Signals
    // ---------------------------------------------------------------
    logic              sys_clk;    // 200 MHz clock
    logic              sys_rst;    // Sync reset
    pif_pkg::pif_bus_t bus;        // Register bus request
    logic [7:0]        rdata_r;    // Read data
    logic              irq;        // Interrupt line
    logic [7:0]        s6, s7, s8; // Event pulses
    pif_pkg::pif_src_t src;        // Peripheral sources
    logic              rd_d;       // Read seen last edge
    logic [15:0]       exp_q[$];   // Notes: mask, value
    logic [15:0]       e;          // Oldest note
    pif_pkg::pif_src_t s;          // Source pattern
    logic [7:0]        r6, r7, r8, v, e7, e8;
    int                errors, n_compared;
    // ---------------------------------------------------------------
    // Design, partner and clock
    // ---------------------------------------------------------------
    pif_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus_in(bus),
        .rdata_r(rdata_r), .set6_pulse(s6), .set7_pulse(s7),
        .set8_pulse(s8), .src_in(src), .irq(irq));
    pif_periph_model model (.sys_clk(sys_clk), .set6_pulse(s6),
        .set7_pulse(s7), .set8_pulse(s8), .src_out(src));
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // One bus cycle; a read also leaves a note for the monitor
    task automatic op(input logic w, input logic [11:0] a,
                      input logic [7:0] d, ev, m);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, wr: w, rd: !w};
        if (!w) exp_q.push_back({m, ev});
        @(posedge sys_clk);
        bus <= '0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge sys_clk) rd_d <= bus.rd;
    always @(negedge sys_clk) begin
        if (rd_d) begin
            e = exp_q.pop_front();
            `CHK(rdata_r & e[15:8], e[7:0])
        end
    end
    // Counts, verdict and end of run
    task automatic close_out();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles needed
    initial begin
        #20000;
        errors++;
        close_out();
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        bus = '0;
        rd_d = 1'b0;
        errors = 0;
        n_compared = 0;
        v = 8'($urandom(2));
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        op(0, pif_pkg::PIF_OFS_REQ6, 0, 8'h00, 8'hFF);
        op(0, pif_pkg::PIF_OFS_REQ7, 0, 8'h00, 8'hFF);
        op(0, pif_pkg::PIF_OFS_REQ8, 0, 8'h00, 8'hFF);
        op(0, 12'h123, 0, 8'h00, 8'hFF);
        $display("reset values done");
        // Random events stay until software writes zero
        for (int i = 0; i < 3; i++) begin
            r6 = 8'($urandom);
            r7 = 8'($urandom);
            r8 = 8'($urandom);
            model.pulse(r6, r7, r8);
            repeat (4) @(posedge sys_clk);
            op(0, pif_pkg::PIF_OFS_REQ6, 0, r6, 8'hFF);
            op(0, pif_pkg::PIF_OFS_REQ7, 0, r7 & 8'h60, 8'hFF);
            op(0, pif_pkg::PIF_OFS_REQ8, 0, r8 & 8'hF0, 8'hFF);
            op(1, pif_pkg::PIF_OFS_REQ6, ~r6, 0, 0);
            op(0, pif_pkg::PIF_OFS_REQ6, 0, ~r6, 8'hFF);
            op(1, pif_pkg::PIF_OFS_REQ6, 8'h00, 0, 0);
            op(1, pif_pkg::PIF_OFS_REQ7, 8'h00, 0, 0);
            op(1, pif_pkg::PIF_OFS_REQ8, 8'h00, 0, 0);
            op(0, pif_pkg::PIF_OFS_REQ6, 0, 8'h00, 8'hFF);
        end
        // An event beside a clearing write wins
        fork
            model.pulse(8'h01, 8'h00, 8'h00);
            op(1, pif_pkg::PIF_OFS_REQ6, 8'h00, 0, 0);
        join
        op(0, pif_pkg::PIF_OFS_REQ6, 0, 8'h01, 8'hFF);
        $display("sticky flags done");
        // Each summary bit follows the OR of its source register, or its single buffer flag
        for (int k = 0; k < 9; k++) begin
            s = '0;
            v = 8'h01 << ($urandom % 8);
            e7 = 8'h00;
            e8 = 8'h00;
            case (k)
                0: begin s.pwm_three_group_irq_reg = v; e7 = 8'h80; end
                1: begin s.i2c_one_error_reg = v; e7 = 8'h08; end
                2: begin s.i2c_one_protocol_irq_reg = v; e7 = 8'h04; end
                3: begin s.i2c_one_transmit_flag = 1'b1; e7 = 8'h02; end
                4: begin s.i2c_one_receive_flag = 1'b1; e7 = 8'h01; end
                5: begin s.uart_two_irq_reg = v; e8 = 8'h08; end
                6: begin s.uart_two_error_reg = v; e8 = 8'h04; end
                7: begin s.uart_two_transmit_flag = 1'b1; e8 = 8'h02; end
                default: begin s.uart_two_receive_flag = 1'b1; e8 = 8'h01; end
            endcase
            model.load_src(s);
            op(1, pif_pkg::PIF_OFS_REQ7, 8'h9F, 0, 0);
            op(1, pif_pkg::PIF_OFS_REQ8, 8'h0F, 0, 0);
            op(0, pif_pkg::PIF_OFS_REQ7, 0, e7, 8'hFF);
            op(0, pif_pkg::PIF_OFS_REQ8, 0, e8, 8'hFF);
            if (k == 3 || k == 4) model.clear_buffers();
            else model.load_src('0);
            op(0, pif_pkg::PIF_OFS_REQ7, 0, 8'h00, 8'hFF);
            op(0, pif_pkg::PIF_OFS_REQ8, 0, 8'h00, 8'hFF);
        end
        $display("summary flags done");
        // Clear stale events before unmasking
        op(1, pif_pkg::PIF_OFS_REQ6, 8'h00, 0, 0);
        op(0, pif_pkg::PIF_OFS_STAT, 0, 8'h07, 8'hFF);
        op(1, pif_pkg::PIF_OFS_MASK, 8'h01, 0, 0);
        @(negedge sys_clk);
        `CHK(irq, 1'b0)
        model.pulse(8'h10, 8'h00, 8'h00);
        repeat (3) @(negedge sys_clk);
        `CHK(irq, 1'b1)
        op(0, pif_pkg::PIF_OFS_STAT, 0, 8'h01, 8'h07);
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        model.pulse(8'h00, 8'h00, 8'h80);
        repeat (3) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        op(0, pif_pkg::PIF_OFS_STAT, 0, 8'h04, 8'h07);
        op(0, pif_pkg::PIF_OFS_MASK, 0, 8'h01, 8'h07);
        $display("interrupt done");
        close_out();
    end
endmodule
`default_nettype wire
